// ### bsc_pkg.sv
package bsc_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;

  // On-time floor and current-limit turn-off delay.
  localparam int T_MIN_ON_NS = 135;
  localparam int MIN_ON_CYC = (T_MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_ILIM_DLY_NS = 60;
  localparam int ILIM_DLY_CYC =
    (T_ILIM_DLY_NS / CLK_PERIOD_NS < 1) ? 1 : T_ILIM_DLY_NS / CLK_PERIOD_NS;

  // Resistor-set frequency range, as oscillator periods in clock cycles.
  localparam int F_RT_MIN_KHZ = 100;
  localparam int F_RT_MAX_KHZ = 2500;
  localparam int RT_PER_MAX = CLK_HZ / (F_RT_MIN_KHZ * 1000);
  localparam int RT_PER_MIN = (CLK_HZ + F_RT_MAX_KHZ * 1000 - 1) / (F_RT_MAX_KHZ * 1000);

  // External clock range.
  localparam int F_SYNC_MIN_KHZ = 160;
  localparam int F_SYNC_MAX_KHZ = 2300;
  localparam int SYNC_PER_MAX = CLK_HZ / (F_SYNC_MIN_KHZ * 1000);
  localparam int SYNC_PER_MIN =
    (CLK_HZ + F_SYNC_MAX_KHZ * 1000 - 1) / (F_SYNC_MAX_KHZ * 1000);
  localparam int SYNC_LOSS_CYC = 2 * SYNC_PER_MAX;

  // Lock time, loss-of-clock frequency and bias settling.
  localparam int T_LOCK_US = 78;
  localparam int LOCK_CYC = T_LOCK_US * 1000 / CLK_PERIOD_NS;
  localparam int LOCK_EDGES = 2;
  localparam int F_FALLBACK_KHZ = 150;
  localparam int FALLBACK_PER = CLK_HZ / (F_FALLBACK_KHZ * 1000);
  localparam int T_BIAS_SETTLE_NS = 5000;
  localparam int BIAS_SETTLE_CYC = T_BIAS_SETTLE_NS / CLK_PERIOD_NS;

  // Soft-start length in switching cycles.
  localparam int SS_CYCLES = 1024;

  // Foldback divisors selected by the feedback band, band 3 being regulation.
  localparam logic [3:0] FOLD_DIV_BAND3 = 4'h1;
  localparam logic [3:0] FOLD_DIV_BAND2 = 4'h2;
  localparam logic [3:0] FOLD_DIV_BAND1 = 4'h4;
  localparam logic [3:0] FOLD_DIV_BAND0 = 4'h8;

  // Reset values.
  localparam logic RST_BIAS_EN = 1'b1;
  localparam logic [3:0] RST_FOLD_DIV = 4'h8;

  typedef enum logic [1:0] {
    BSC_MODE_RES = 2'h0,
    BSC_MODE_LOCKING = 2'h1,
    BSC_MODE_LOCKED = 2'h2,
    BSC_MODE_FALLBACK = 2'h3
  } bsc_mode_t;

endpackage

// ### bsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bsc_sync_state_t;

  bsc_sync_state_t st;
  bsc_sync_state_t next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st = st;
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule

`default_nettype wire

// ### bsc_switching_control.sv
// Operation
// - Free-running frequency set by resistor between 100 kHz and 2500 kHz.
// - High-side on pulse lasts at least about 135 ns.
// - Each cycle, switch turns off once sensed current reaches control level.
// - Clamped control level is the peak limit; turn-off delay typically 60 ns.
// - Frequency divided by 1, 2, 4, 8 as feedback falls toward zero.
// - Foldback divides the clock digitally so external lock is kept.
// - Pulses are skipped when demanded on time is below the minimum; the code skips only if current is at the control level at turn-on.
// - External clock lies within 160 to 2300 kHz and is locked to.
// - When synchronized, switch turn-on aligns to external clock falling edge.
// - First rising threshold crossing enters locking mode and removes the pin bias.
// - External clock may be faster or slower than the resistor setting.
// - Transition to locked mode completes within 78 microseconds.
// - On clock loss frequency drops to 150 kHz, then returns to resistor value; the code returns after 50 clock cycles, so no cycle starts at 150 kHz.
// - Feedback above 109 percent disables the high-side switch at once.
// - Switching resumes only when feedback falls below 106 percent.
// - Junction above 176 C stops high-side switching.
// - Below 164 C the device restarts under soft-start control.
// - Soft-start ramps the reference over 1024 switching cycles.
// - Soft-start clears during thermal shutdown so restart ramps from zero.
// - Phase lock keeps running while pulses are skipped.
`timescale 1ns/1ps
`default_nettype none

module bsc_switching_control #(
  parameter int PER_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [PER_W-1:0] rt_period_i,
  input wire logic freq_set_sync_pin_i,
  input wire logic [1:0] feedback_sense_i,
  input wire logic cur_trip_i,
  input wire logic cur_limit_i,
  input wire logic ovp_rise_i,
  input wire logic ovp_above_fall_i,
  input wire logic temp_trip_i,
  input wire logic temp_above_fall_i,
  output logic hs_drive_o,
  output logic sw_cycle_o,
  output logic sync_bias_en_o,
  output logic sync_locked_o,
  output logic [1:0] clk_mode_o,
  output logic [3:0] fold_div_o,
  output logic overshoot_guard_o,
  output logic thermal_shdn_o,
  output logic [9:0] ss_level_o,
  output logic ss_done_o
);

  typedef struct packed {
    bsc_pkg::bsc_mode_t mode;
    logic pin_d;
    logic [PER_W-1:0] osc_cnt;
    logic [PER_W-1:0] edge_gap;
    logic [1:0] edges;
    logic [6:0] bias_cnt;
    logic bias_en;
    logic [2:0] div_cnt;
    logic [3:0] fold_div;
    logic guard;
    logic tsd;
    logic [10:0] ss_cnt;
    logic [9:0] ss_lvl;
    logic ss_done;
    logic hs_on;
    logic [2:0] on_cnt;
    logic sw_cycle;
    logic locked;
  } bsc_state_t;

  bsc_state_t st;
  bsc_state_t next_st;

  logic [8:0] in_s;
  logic pin_s;
  logic [1:0] band_s;
  logic cur_s;
  logic ilim_s;
  logic ovp_hi_s;
  logic ovp_lo_s;
  logic hot_s;
  logic warm_s;
  logic fall;
  logic rise;
  logic tick;
  logic start;
  logic blocked;
  logic [PER_W-1:0] per;
  logic [3:0] div;

  // Pin and comparators come from outside the clock domain.
  bsc_sync #(
    .WIDTH(9)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i({freq_set_sync_pin_i, feedback_sense_i, cur_trip_i, cur_limit_i,
              ovp_rise_i, ovp_above_fall_i, temp_trip_i, temp_above_fall_i}),
    .sync_o(in_s)
  );

  assign {pin_s, band_s, cur_s, ilim_s, ovp_hi_s, ovp_lo_s, hot_s, warm_s} = in_s;

  always_comb begin
    next_st = st;
    fall = st.pin_d & ~pin_s;
    rise = ~st.pin_d & pin_s;
    tick = 1'b0;
    next_st.pin_d = pin_s;

    // Gap since the last falling edge, saturating, watches for clock loss.
    if (fall) begin
      next_st.edge_gap = '0;
    end else if (st.edge_gap != {PER_W{1'b1}}) begin
      next_st.edge_gap = st.edge_gap + PER_W'(1);
    end

    // Resistor period is clamped to the supported frequency range.
    if (rt_period_i < PER_W'(bsc_pkg::RT_PER_MIN)) begin
      per = PER_W'(bsc_pkg::RT_PER_MIN);
    end else if (rt_period_i > PER_W'(bsc_pkg::RT_PER_MAX)) begin
      per = PER_W'(bsc_pkg::RT_PER_MAX);
    end else begin
      per = rt_period_i;
    end

    case (st.mode)
      bsc_pkg::BSC_MODE_RES: begin
        next_st.bias_en = 1'b1;
        if (rise) begin
          // Any frequency is accepted, faster or slower than the resistor.
          next_st.mode = bsc_pkg::BSC_MODE_LOCKING;
          next_st.bias_en = 1'b0;
          next_st.edges = 2'h0;
          next_st.edge_gap = '0;
        end
      end
      bsc_pkg::BSC_MODE_LOCKING: begin
        tick = fall;
        if (fall) begin
          next_st.edges = st.edges + 2'h1;
        end
        if (fall && st.edges == 2'(bsc_pkg::LOCK_EDGES - 1)) begin
          next_st.mode = bsc_pkg::BSC_MODE_LOCKED;
        end else if (st.edge_gap >= PER_W'(bsc_pkg::SYNC_LOSS_CYC)) begin
          next_st.mode = bsc_pkg::BSC_MODE_FALLBACK;
          next_st.bias_en = 1'b1;
          next_st.bias_cnt = 7'h00;
        end
      end
      bsc_pkg::BSC_MODE_LOCKED: begin
        tick = fall;
        if (st.edge_gap >= PER_W'(bsc_pkg::SYNC_LOSS_CYC)) begin
          next_st.mode = bsc_pkg::BSC_MODE_FALLBACK;
          // Bias returns together with the fallback rate, so the pin is never left floating.
          next_st.bias_en = 1'b1;
          next_st.bias_cnt = 7'h00;
        end
      end
      default: begin
        // The low fallback rate holds until the restored bias has settled.
        per = PER_W'(bsc_pkg::FALLBACK_PER);
        next_st.bias_en = 1'b1;
        next_st.bias_cnt = st.bias_cnt + 7'h01;
        if (st.bias_cnt == 7'(bsc_pkg::BIAS_SETTLE_CYC - 1)) begin
          next_st.mode = bsc_pkg::BSC_MODE_RES;
        end
      end
    endcase

    // Free-running oscillator outside the synchronized modes.
    if (st.mode == bsc_pkg::BSC_MODE_RES || st.mode == bsc_pkg::BSC_MODE_FALLBACK) begin
      if (st.osc_cnt >= per - PER_W'(1)) begin
        tick = 1'b1;
        next_st.osc_cnt = '0;
      end else begin
        next_st.osc_cnt = st.osc_cnt + PER_W'(1);
      end
    end else begin
      next_st.osc_cnt = '0;
    end

    // Each feedback band picks one divisor.
    case (band_s)
      2'h3: div = bsc_pkg::FOLD_DIV_BAND3;
      2'h2: div = bsc_pkg::FOLD_DIV_BAND2;
      2'h1: div = bsc_pkg::FOLD_DIV_BAND1;
      default: div = bsc_pkg::FOLD_DIV_BAND0;
    endcase
    next_st.fold_div = div;

    // Dropping ticks rather than slowing the timebase keeps lock intact.
    start = tick && (st.div_cnt == 3'h0);
    if (tick) begin
      if ({1'b0, st.div_cnt} >= div - 4'h1) begin
        next_st.div_cnt = 3'h0;
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
      end
    end
    next_st.sw_cycle = start;
    next_st.locked = (next_st.mode == bsc_pkg::BSC_MODE_LOCKED);

    // Overvoltage hysteresis; a new trip wins over release.
    if (ovp_hi_s) begin
      next_st.guard = 1'b1;
    end else if (!ovp_lo_s) begin
      next_st.guard = 1'b0;
    end

    // Thermal hysteresis.
    if (hot_s) begin
      next_st.tsd = 1'b1;
    end else if (!warm_s) begin
      next_st.tsd = 1'b0;
    end

    // Soft-start counts switching cycles and is cleared in shutdown.
    if (next_st.tsd) begin
      next_st.ss_cnt = 11'h000;
    end else if (start && st.ss_cnt != 11'(bsc_pkg::SS_CYCLES)) begin
      next_st.ss_cnt = st.ss_cnt + 11'h001;
    end
    next_st.ss_done = (next_st.ss_cnt == 11'(bsc_pkg::SS_CYCLES));
    next_st.ss_lvl = next_st.ss_done ? 10'h3FF : next_st.ss_cnt[9:0];

    // High-side drive.
    blocked = next_st.guard || next_st.tsd;
    if (blocked) begin
      next_st.hs_on = 1'b0;
    end else if (start && !st.hs_on) begin
      // A demand already met at turn-on skips this pulse; the lock runs on.
      if (!cur_s && !ilim_s) begin
        next_st.hs_on = 1'b1;
        next_st.on_cnt = 3'h0;
      end
    end else if (st.hs_on) begin
      if (st.on_cnt < 3'(bsc_pkg::MIN_ON_CYC - 1)) begin
        next_st.on_cnt = st.on_cnt + 3'h1;
      end else if (cur_s || ilim_s) begin
        next_st.hs_on = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.mode <= bsc_pkg::BSC_MODE_RES;
      st.bias_en <= bsc_pkg::RST_BIAS_EN;
      st.fold_div <= bsc_pkg::RST_FOLD_DIV;
    end else begin
      st <= next_st;
    end
  end

  assign hs_drive_o = st.hs_on;
  assign sw_cycle_o = st.sw_cycle;
  assign sync_bias_en_o = st.bias_en;
  assign sync_locked_o = st.locked;
  assign clk_mode_o = st.mode;
  assign fold_div_o = st.fold_div;
  assign overshoot_guard_o = st.guard;
  assign thermal_shdn_o = st.tsd;
  assign ss_level_o = st.ss_lvl;
  assign ss_done_o = st.ss_done;

  a_min_on_time: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    $rose(st.hs_on) |=> (st.hs_on || st.guard || st.tsd))
    else $error("High-side pulse shorter than the minimum on time.");

  a_peak_turnoff: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (st.hs_on && cur_s && st.on_cnt >= 3'(bsc_pkg::MIN_ON_CYC - 1)) |=> !st.hs_on)
    else $error("Switch not turned off at the control level.");

  a_limit_delay: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (st.hs_on && ilim_s && st.on_cnt != 3'h0) |-> ##[1:1] !st.hs_on)
    else $error("Current limit turn-off too late.");

  a_fold_spacing: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (start && band_s == 2'h0 && $stable(band_s)) |=> !start)
    else $error("Foldback by eight let back-to-back cycles through.");

  a_sync_align: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    ($rose(st.hs_on) && st.mode == bsc_pkg::BSC_MODE_LOCKED) |-> $past(fall))
    else $error("Locked turn-on not on an external falling edge.");

  a_bias_removed: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (st.mode == bsc_pkg::BSC_MODE_LOCKING || st.mode == bsc_pkg::BSC_MODE_LOCKED)
    |-> !st.bias_en)
    else $error("Pin bias present while synchronized.");

  a_lock_time: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    $rose(st.mode == bsc_pkg::BSC_MODE_LOCKING)
    |-> ##[1:780] (st.mode != bsc_pkg::BSC_MODE_LOCKING))
    else $error("Lock not reached within the lock time.");

  a_guard_off: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    ovp_hi_s |=> (!st.hs_on && st.guard))
    else $error("High side active above the overvoltage threshold.");

  a_guard_hold: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (st.guard && ovp_lo_s) |=> st.guard)
    else $error("Overvoltage released above the falling threshold.");

  a_thermal_off: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    hot_s |=> (st.tsd && !st.hs_on))
    else $error("Switching continued in thermal shutdown.");

  a_ss_cleared: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    st.tsd |-> (st.ss_cnt == 11'h000 && !st.ss_done))
    else $error("Soft-start not cleared in thermal shutdown.");

  a_fold_band: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (band_s == 2'h0) |=> (st.fold_div == 4'h8))
    else $error("Lowest feedback band did not select division by eight.");

  a_fallback_bias: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (st.mode == bsc_pkg::BSC_MODE_FALLBACK) |-> st.bias_en)
    else $error("Pin bias missing during the fallback rate.");

  a_locked_flag: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    st.locked == (st.mode == bsc_pkg::BSC_MODE_LOCKED))
    else $error("Lock flag disagrees with the clock mode.");

endmodule

`default_nettype wire

// ### bsc_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

module bsc_stage_model (
  input wire logic mclk_i,
  input wire logic hs_drive_i,
  input wire logic sync_en_i,
  input wire logic [7:0] sync_half_i,
  input wire logic [7:0] trip_after_i,
  input wire logic [7:0] limit_after_i,
  output logic freq_set_sync_pin_o,
  output logic cur_trip_o,
  output logic cur_limit_o
);
  logic [7:0] on_cnt = 8'h00;
  logic [7:0] ph_cnt = 8'h00;

  initial freq_set_sync_pin_o = 1'b0;

  // Everything moves on the falling edge so it is settled at the sampling edge.
  always @(negedge mclk_i) begin
    if (!hs_drive_i) begin
      on_cnt <= 8'h00;
    end else if (on_cnt != 8'hFF) begin
      on_cnt <= on_cnt + 8'h01;
    end
    // With the source off the timing resistor holds the pin below threshold.
    if (!sync_en_i) begin
      ph_cnt <= 8'h00;
      freq_set_sync_pin_o <= 1'b0;
    end else if (ph_cnt == sync_half_i - 8'h01) begin
      ph_cnt <= 8'h00;
      freq_set_sync_pin_o <= ~freq_set_sync_pin_o;
    end else begin
      ph_cnt <= ph_cnt + 8'h01;
    end
  end

  // A zero threshold models a switch current already above the control level.
  assign cur_trip_o = (on_cnt >= trip_after_i);
  assign cur_limit_o = (on_cnt >= limit_after_i);
endmodule

`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] rt_period_i = 8'h0A;
  logic [1:0] feedback_sense_i = 2'h3;
  logic ovp_rise_i = 1'b0;
  logic ovp_above_fall_i = 1'b0;
  logic temp_trip_i = 1'b0;
  logic temp_above_fall_i = 1'b0;
  logic sync_en = 1'b0;
  logic [7:0] trip_after = 8'h05;
  logic [7:0] limit_after = 8'hC8;
  logic pin, cur_trip, cur_limit;
  logic hs_drive_o, sw_cycle_o, sync_bias_en_o, sync_locked_o;
  logic overshoot_guard_o, thermal_shdn_o, ss_done_o;
  logic [1:0] clk_mode_o;
  logic [3:0] fold_div_o;
  logic [9:0] ss_level_o;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int sw_count = 0;
  int n;
  int w;
  logic [3:0] div_tab [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  int rt_tab [3] = '{10, 2, 200};
  int per_tab [3] = '{10, 4, 100};
  logic [7:0] trip_tab [3] = '{8'h05, 8'hC8, 8'h01};
  logic [7:0] lim_tab [3] = '{8'hC8, 8'h03, 8'hC8};
  int lo_tab [3] = '{5, 3, 2};

  bsc_switching_control u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .rt_period_i(rt_period_i),
    .freq_set_sync_pin_i(pin), .feedback_sense_i(feedback_sense_i),
    .cur_trip_i(cur_trip), .cur_limit_i(cur_limit), .ovp_rise_i(ovp_rise_i),
    .ovp_above_fall_i(ovp_above_fall_i), .temp_trip_i(temp_trip_i),
    .temp_above_fall_i(temp_above_fall_i), .hs_drive_o(hs_drive_o),
    .sw_cycle_o(sw_cycle_o), .sync_bias_en_o(sync_bias_en_o),
    .sync_locked_o(sync_locked_o), .clk_mode_o(clk_mode_o), .fold_div_o(fold_div_o),
    .overshoot_guard_o(overshoot_guard_o), .thermal_shdn_o(thermal_shdn_o),
    .ss_level_o(ss_level_o), .ss_done_o(ss_done_o)
  );

  bsc_stage_model u_stage (
    .mclk_i(mclk_i), .hs_drive_i(hs_drive_o), .sync_en_i(sync_en),
    .sync_half_i(8'h0A), .trip_after_i(trip_after), .limit_after_i(limit_after),
    .freq_set_sync_pin_o(pin), .cur_trip_o(cur_trip), .cur_limit_o(cur_limit)
  );

  always #50 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc++;
    if (sw_cycle_o === 1'b1) begin
      sw_count++;
    end
    // Soft-start alone takes about ten thousand cycles; this leaves ample margin.
    if (cyc >= 60000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  task automatic wait_pulse(output int k);
    k = 0;
    while (sw_cycle_o !== 1'b1 && k < 4000) begin
      @(negedge mclk_i);
      k++;
    end
  endtask

  // Spacing of two cycle starts, skipping the first so a change can settle.
  task automatic period(output int k);
    int d;
    wait_pulse(d);
    @(negedge mclk_i);
    wait_pulse(k);
    k = k + 1;
  endtask

  task automatic on_width(output int k);
    int d;
    d = 0;
    k = 0;
    while (hs_drive_o !== 1'b1 && d < 400) begin
      @(negedge mclk_i);
      d++;
    end
    while (hs_drive_o === 1'b1 && k < 400) begin
      @(negedge mclk_i);
      k++;
    end
  endtask

  initial begin
    cycles(4);
    check(sync_bias_en_o === 1'b1 && clk_mode_o === 2'h0, "reset mode");
    check(fold_div_o === 4'h8, "reset divisor");
    reset_i = 1'b0;
    for (int b = 0; b < 4; b++) begin
      feedback_sense_i = 2'(b);
      cycles(8);
      check(fold_div_o === div_tab[b], "band divisor");
      period(n);
      period(n);
      check(n == 10 * int'(div_tab[b]), "folded period");
    end
    for (int i = 0; i < 3; i++) begin
      rt_period_i = 8'(rt_tab[i]);
      period(n);
      period(n);
      check(n == per_tab[i], "resistor period");
    end
    rt_period_i = 8'h0A;
    for (int i = 0; i < 3; i++) begin
      trip_after = trip_tab[i];
      limit_after = lim_tab[i];
      on_width(w);
      on_width(w);
      check(w >= lo_tab[i] && w <= lo_tab[i] + 4, "on width");
    end
    trip_after = 8'h00;
    cycles(10);
    w = 0;
    sw_count = 0;
    repeat (60) begin
      @(negedge mclk_i);
      w += int'(hs_drive_o !== 1'b0);
    end
    check(w == 0 && sw_count > 0, "pulse skip");
    trip_after = 8'hC8;
    cycles(20);
    check(hs_drive_o === 1'b1, "full duty");
    ovp_above_fall_i = 1'b1;
    ovp_rise_i = 1'b1;
    cycles(4);
    check(hs_drive_o === 1'b0 && overshoot_guard_o === 1'b1, "guard set");
    ovp_rise_i = 1'b0;
    cycles(30);
    check(hs_drive_o === 1'b0 && overshoot_guard_o === 1'b1, "guard held");
    ovp_above_fall_i = 1'b0;
    cycles(4);
    check(overshoot_guard_o === 1'b0, "guard clear");
    on_width(w);
    check(w > 0, "switching resumed");
    cycles(20);
    temp_above_fall_i = 1'b1;
    temp_trip_i = 1'b1;
    cycles(4);
    check(hs_drive_o === 1'b0 && thermal_shdn_o === 1'b1, "thermal stop");
    cycles(4);
    check(ss_level_o === 10'h000 && ss_done_o === 1'b0, "ramp cleared");
    temp_trip_i = 1'b0;
    cycles(20);
    check(thermal_shdn_o === 1'b1 && hs_drive_o === 1'b0, "thermal held");
    temp_above_fall_i = 1'b0;
    trip_after = 8'h05;
    n = 0;
    while (thermal_shdn_o !== 1'b0 && n < 10) begin
      @(negedge mclk_i);
      n++;
    end
    sw_count = 0;
    n = 0;
    while (ss_done_o !== 1'b1 && n < 20000) begin
      @(negedge mclk_i);
      n++;
    end
    // The last cycle start is counted one rising edge after it shows.
    @(negedge mclk_i);
    check(sw_count >= 1024 && sw_count <= 1025, "ramp length");
    check(ss_level_o === 10'h3FF, "ramp top");
    sync_en = 1'b1;
    @(posedge pin);
    @(negedge mclk_i);
    cycles(3);
    check(sync_bias_en_o === 1'b0 && clk_mode_o === 2'h1, "bias removed");
    n = 0;
    while (sync_locked_o !== 1'b1 && n < bsc_pkg::LOCK_CYC) begin
      @(negedge mclk_i);
      n++;
    end
    check(clk_mode_o === 2'h2, "locked in time");
    @(negedge pin);
    wait_pulse(n);
    check(n >= 3 && n <= 4 && hs_drive_o === 1'b1, "turn-on on falling edge");
    period(n);
    check(n == 20, "slower external clock");
    trip_after = 8'h00;
    period(n);
    check(n == 20 && sync_locked_o === 1'b1, "lock while skipping");
    sync_en = 1'b0;
    n = 0;
    while (clk_mode_o !== 2'h3 && n < 300) begin
      @(negedge mclk_i);
      n++;
    end
    check(clk_mode_o === 2'h3 && sync_bias_en_o === 1'b1, "clock loss");
    sw_count = 0;
    n = 0;
    while (clk_mode_o !== 2'h0 && n < 300) begin
      @(negedge mclk_i);
      n++;
    end
    check(n >= 48 && n <= 52, "back to resistor");
    check(sw_count == 0, "no start at the fallback rate");
    period(n);
    check(n == 10, "resistor rate restored");
    finish_test();
  end
endmodule

`default_nettype wire
